/* File: vis_consts.svh */
// constants of the vectored interrupt sequencer
`ifndef VIS_CONSTS_SVH
`define VIS_CONSTS_SVH

// source count and which sources are level type
`define VIS_NSRC 9
`define VIS_LEVEL_MASK 9'h040

// register offsets on the plain register port
`define VIS_OFF_STATUS 4'h0
`define VIS_OFF_ENABLE 4'h1
`define VIS_OFF_FLAGS 4'h2
`define VIS_OFF_REQ 4'h3
`define VIS_OFF_SP 4'h4

// field positions and reset values
`define VIS_GIE_BIT 7
`define VIS_SP_RESET 8'h9f
`define VIS_RESET_VEC 9'h000

// cycle counts of the sequences
`define VIS_ENTRY_CYC 3'h4
`define VIS_WAKE_CYC 3'h4
`define VIS_RET_CYC 3'h4

`endif

/* File: vis_pkg.sv */
// types shared by the interrupt sequencer modules
`default_nettype none
`include "vis_consts.svh"
package vis_pkg;
   typedef logic [`VIS_NSRC-1:0] vis_src_t;
   typedef logic [3:0] vis_idx_t;
   typedef enum logic [2:0] {
      VIS_RST_VEC = 3'b000,
      VIS_IDLE = 3'b001,
      VIS_WAKE = 3'b010,
      VIS_ENTRY = 3'b011,
      VIS_RETURN = 3'b100
   } vis_state_t;
endpackage
`default_nettype wire

/* File: vis_src_if.sv */
// bundle between the sequencer, the flag bank and the priority picker
`default_nettype none
interface vis_src_if;
   import vis_pkg::*;
   vis_src_t evt;
   vis_src_t sw_clr;
   vis_src_t hw_clr;
   vis_src_t en;
   vis_src_t flag;
   vis_src_t req;
   logic any;
   vis_idx_t idx;
   modport flags_mp (
      input evt, sw_clr, hw_clr, en,
      output flag, req
   );
   modport prio_mp (
      input req,
      output any, idx
   );
endinterface
`default_nettype wire

/* File: vis_flags.sv */
// pending flags of latched sources and live requests of level sources
`default_nettype none
module vis_flags
   import vis_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // bundle
   vis_src_if.flags_mp s
);
   localparam vis_src_t LEVEL = `VIS_LEVEL_MASK;
   vis_src_t flag_q;
   vis_src_t flag_d;

   genvar i;
   generate
      for (i = 0; i < `VIS_NSRC; i++) begin : g_bit
         if (LEVEL[i]) begin : g_level
            // no memory: a condition gone before enable is never taken
            assign flag_d[i] = 1'b0;
            assign s.req[i] = s.evt[i] & s.en[i];
         end else begin : g_latch
            // set beats any clear in the same cycle
            assign flag_d[i] = s.evt[i] |
               (flag_q[i] & ~s.sw_clr[i] & ~s.hw_clr[i]);
            assign s.req[i] = flag_q[i] & s.en[i];
         end
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign s.flag = flag_q;
endmodule
`default_nettype wire

/* File: vis_prio.sv */
// fixed priority picker: lowest source index wins
`default_nettype none
module vis_prio
   import vis_pkg::*;
(
   // bundle
   vis_src_if.prio_mp s
);
   always_comb begin
      s.any = 1'b0;
      s.idx = '0;
      for (int k = `VIS_NSRC - 1; k >= 0; k--) begin
         if (s.req[k]) begin
            s.any = 1'b1;
            s.idx = vis_idx_t'(k);
         end
      end
   end
endmodule
`default_nettype wire

/* File: vis_top.sv */
// vectored interrupt and reset sequencer for a small 8-bit core
//
// Added by the designer: the address map and strobed register access.
`default_nettype none
`include "vis_consts.svh"
module vis_top
   import vis_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   // interrupt sources
   input wire logic [`VIS_NSRC-1:0] src_i,
   // core pipeline
   input wire logic retire_i,
   input wire logic cli_i,
   input wire logic sei_i,
   input wire logic return_from_irq_instr_i,
   input wire logic sleep_i,
   input wire logic [8:0] pc_i,
   output logic stall_o,
   output logic pc_load_o,
   output logic [8:0] pc_o,
   output logic ack_o,
   output logic [3:0] ack_src_o,
   output logic gie_o,
   // stack memory
   output logic stk_we_o,
   output logic stk_re_o,
   output logic [7:0] stk_addr_o,
   output logic [7:0] stk_wdata_o,
   input wire logic [7:0] stk_rdata_i
);
   vis_src_if s ();

   vis_flags u_flags (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .s(s.flags_mp)
   );

   vis_prio u_prio (
      .s(s.prio_mp)
   );

   // sequencer and register state
   vis_state_t state_q, state_d;
   logic [2:0] cnt_q, cnt_d;
   logic gie_q, gie_d;
   logic [6:0] status_flag_register_lo_q, status_flag_register_lo_d;
   vis_src_t en_q, en_d;
   logic [7:0] sp_q, sp_d;
   logic block_q, block_d;
   logic [8:0] pcs_q, pcs_d;
   vis_idx_t sel_q, sel_d;
   logic pop_hi_q, pop_hi_d;
   logic stall_q, stall_d;
   logic pc_load_q, pc_load_d;
   logic [8:0] pc_q, pc_d;
   logic ack_q, ack_d;
   logic stk_we_q, stk_we_d;
   logic stk_re_q, stk_re_d;
   logic [7:0] stk_addr_q, stk_addr_d;
   logic [7:0] stk_wdata_q, stk_wdata_d;
   logic [7:0] rdata_q, rdata_d;
   vis_src_t hw_clr;
   logic take;
   logic wr_status;

   assign wr_status = reg_we_i && reg_addr_i == `VIS_OFF_STATUS;

   // a take needs an instruction boundary or a sleeping core
   assign take = state_q == VIS_IDLE && gie_q && !cli_i && !block_q &&
      s.any && (retire_i || sleep_i);

   always_comb begin
      hw_clr = '0;
      if (take) begin
         hw_clr[s.idx] = 1'b1;
      end
   end

   assign s.evt = src_i;
   assign s.en = en_q;
   assign s.hw_clr = hw_clr;
   assign s.sw_clr = (reg_we_i && reg_addr_i == `VIS_OFF_FLAGS) ?
      vis_src_t'({1'b0, reg_wdata_i}) : '0;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 3'h1;
      gie_d = gie_q;
      status_flag_register_lo_d = status_flag_register_lo_q;
      en_d = en_q;
      sp_d = sp_q;
      block_d = block_q;
      pcs_d = pcs_q;
      sel_d = sel_q;
      pop_hi_d = pop_hi_q;
      stall_d = stall_q;
      pc_load_d = 1'b0;
      pc_d = pc_q;
      ack_d = 1'b0;
      stk_we_d = 1'b0;
      stk_re_d = 1'b0;
      stk_addr_d = stk_addr_q;
      stk_wdata_d = stk_wdata_q;

      // software side of the status, mask and stack pointer registers
      if (wr_status) begin
         gie_d = reg_wdata_i[`VIS_GIE_BIT];
         status_flag_register_lo_d = reg_wdata_i[6:0];
      end
      if (reg_we_i && reg_addr_i == `VIS_OFF_ENABLE) begin
         en_d = vis_src_t'({1'b0, reg_wdata_i});
      end
      if (reg_we_i && reg_addr_i == `VIS_OFF_SP) begin
         sp_d = reg_wdata_i;
      end
      if (retire_i && cli_i) begin
         gie_d = 1'b0;
      end
      // the one-instruction hold ends on the next retired instruction
      if (retire_i && state_q == VIS_IDLE) begin
         block_d = 1'b0;
      end
      if (retire_i && sei_i) begin
         gie_d = 1'b1;
         block_d = 1'b1;
      end

      unique case (state_q)
         VIS_RST_VEC: begin
            // reset vector is always served first
            pc_load_d = 1'b1;
            pc_d = `VIS_RESET_VEC;
            stall_d = 1'b0;
            state_d = VIS_IDLE;
         end
         VIS_IDLE: begin
            cnt_d = '0;
            if (take) begin
               gie_d = 1'b0;
               sel_d = s.idx;
               pcs_d = pc_i;
               ack_d = 1'b1;
               stall_d = 1'b1;
               if (sleep_i && !retire_i) begin
                  state_d = VIS_WAKE;
               end else begin
                  // low byte first, post-decrement
                  stk_we_d = 1'b1;
                  stk_addr_d = sp_q;
                  stk_wdata_d = pc_i[7:0];
                  sp_d = sp_q - 8'h01;
                  state_d = VIS_ENTRY;
               end
            end else if (retire_i && return_from_irq_instr_i) begin
               stall_d = 1'b1;
               stk_re_d = 1'b1;
               stk_addr_d = sp_q + 8'h01;
               sp_d = sp_q + 8'h01;
               state_d = VIS_RETURN;
            end
         end
         VIS_WAKE: begin
            if (cnt_q == `VIS_WAKE_CYC - 3'h1) begin
               stk_we_d = 1'b1;
               stk_addr_d = sp_q;
               stk_wdata_d = pcs_q[7:0];
               sp_d = sp_q - 8'h01;
               cnt_d = '0;
               state_d = VIS_ENTRY;
            end
         end
         VIS_ENTRY: begin
            // the status register is left alone here
            if (cnt_q == 3'h0) begin
               stk_we_d = 1'b1;
               stk_addr_d = sp_q;
               stk_wdata_d = {7'h00, pcs_q[8]};
               sp_d = sp_q - 8'h01;
            end
            if (cnt_q == `VIS_ENTRY_CYC - 3'h2) begin
               pc_load_d = 1'b1;
               pc_d = 9'({5'h00, sel_q} + 9'h001);
            end
            if (cnt_q == `VIS_ENTRY_CYC - 3'h1) begin
               stall_d = 1'b0;
               state_d = VIS_IDLE;
            end
         end
         VIS_RETURN: begin
            if (cnt_q == 3'h0) begin
               stk_re_d = 1'b1;
               stk_addr_d = sp_q + 8'h01;
               sp_d = sp_q + 8'h01;
            end
            if (cnt_q == 3'h1) begin
               pop_hi_d = stk_rdata_i[0];
            end
            if (cnt_q == `VIS_RET_CYC - 3'h2) begin
               pc_load_d = 1'b1;
               pc_d = {pop_hi_q, stk_rdata_i};
               gie_d = 1'b1;
            end
            if (cnt_q == `VIS_RET_CYC - 3'h1) begin
               stall_d = 1'b0;
               block_d = 1'b1;
               state_d = VIS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= VIS_RST_VEC;
         cnt_q <= '0;
         gie_q <= 1'b0;
         status_flag_register_lo_q <= '0;
         en_q <= '0;
         sp_q <= `VIS_SP_RESET;
         block_q <= 1'b0;
         pcs_q <= '0;
         sel_q <= '0;
         pop_hi_q <= 1'b0;
         stall_q <= 1'b1;
         pc_load_q <= 1'b0;
         pc_q <= '0;
         ack_q <= 1'b0;
         stk_we_q <= 1'b0;
         stk_re_q <= 1'b0;
         stk_addr_q <= '0;
         stk_wdata_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         gie_q <= gie_d;
         status_flag_register_lo_q <= status_flag_register_lo_d;
         en_q <= en_d;
         sp_q <= sp_d;
         block_q <= block_d;
         pcs_q <= pcs_d;
         sel_q <= sel_d;
         pop_hi_q <= pop_hi_d;
         stall_q <= stall_d;
         pc_load_q <= pc_load_d;
         pc_q <= pc_d;
         ack_q <= ack_d;
         stk_we_q <= stk_we_d;
         stk_re_q <= stk_re_d;
         stk_addr_q <= stk_addr_d;
         stk_wdata_q <= stk_wdata_d;
      end
   end

   // register readback, valid the cycle after the strobe only
   always_comb begin
      rdata_d = 8'h00;
      if (reg_re_i) begin
         unique case (reg_addr_i)
            `VIS_OFF_STATUS: rdata_d = {gie_q, status_flag_register_lo_q};
            `VIS_OFF_ENABLE: rdata_d = en_q[7:0];
            `VIS_OFF_FLAGS: rdata_d = s.flag[7:0];
            `VIS_OFF_REQ: rdata_d = s.req[7:0];
            `VIS_OFF_SP: rdata_d = sp_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // only eight sources fit the byte-wide registers; the ninth is hidden
   assign reg_rdata_o = rdata_q;
   assign stall_o = stall_q;
   assign pc_load_o = pc_load_q;
   assign pc_o = pc_q;
   assign ack_o = ack_q;
   assign ack_src_o = sel_q;
   assign gie_o = gie_q;
   assign stk_we_o = stk_we_q;
   assign stk_re_o = stk_re_q;
   assign stk_addr_o = stk_addr_q;
   assign stk_wdata_o = stk_wdata_q;
endmodule
`default_nettype wire

/* File: vis_checker.sv */
// assertions on the sequencer top ports, bound into vis_top
`default_nettype none
module vis_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // core pipeline
   input wire logic retire_i,
   input wire logic cli_i,
   input wire logic sei_i,
   input wire logic return_from_irq_instr_i,
   input wire logic stall_o,
   input wire logic pc_load_o,
   input wire logic [8:0] pc_o,
   input wire logic ack_o,
   input wire logic [3:0] ack_src_o,
   input wire logic gie_o,
   // stack memory
   input wire logic stk_we_o,
   input wire logic [7:0] stk_addr_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // awake entry pushes in its ack cycle; a wake entry does not
   a_take_gie: assert property (ack_o |-> $past(gie_o))
      else $error("interrupt taken with global enable low");
   a_ack_gie: assert property (ack_o |-> !gie_o)
      else $error("global enable still set after accept");
   a_entry_stall: assert property (ack_o && stk_we_o |->
      stall_o [*4] ##1 !stall_o)
      else $error("entry hold is not four cycles");
   a_entry_vec: assert property (ack_o && stk_we_o |->
      ##3 pc_load_o && pc_o == {5'h00, ack_src_o} + 9'h001)
      else $error("wrong vector or vector time");
   a_push_pair: assert property (ack_o && stk_we_o |=>
      stk_we_o && stk_addr_o == $past(stk_addr_o) - 8'h01)
      else $error("second push not one below the first");
   a_wake_len: assert property (ack_o && !stk_we_o |->
      ##4 stk_we_o ##1 stk_we_o ##2 pc_load_o)
      else $error("wake entry not four cycles longer");
   a_cli_block: assert property (retire_i && cli_i |=> !ack_o)
      else $error("interrupt taken with disable instruction");
   a_sei_wait: assert property (retire_i && sei_i |=> !ack_o)
      else $error("interrupt taken right at enable instruction");
   // load and enable land together four cycles after the return retires
   a_ret_len: assert property (retire_i && return_from_irq_instr_i &&
      !stall_o && !gie_o |-> ##4 pc_load_o && gie_o ##1 gie_o)
      else $error("return sequence length or enable wrong");
   cover property (ack_o && stk_we_o);
   cover property (ack_o && !stk_we_o);
   cover property (retire_i && return_from_irq_instr_i);
endmodule
bind vis_top vis_checker i_chk (
   .clk_i, .rst_n_i, .retire_i, .cli_i, .sei_i,
   .return_from_irq_instr_i, .stall_o, .pc_load_o, .pc_o,
   .ack_o, .ack_src_o, .gie_o, .stk_we_o, .stk_addr_o
);
`default_nettype wire

/* File: vis_core_model.sv */
// core pipeline and stack memory on the far side of the sequencer
`default_nettype none
module vis_core_model (
   // clock
   input wire logic clk_i,
   // pipeline control
   input wire logic run_i,
   input wire logic sleep_i,
   input wire logic stall_i,
   output logic retire_o,
   // stack memory
   input wire logic stk_we_i,
   input wire logic stk_re_i,
   input wire logic [7:0] stk_addr_i,
   input wire logic [7:0] stk_wdata_i,
   output logic [7:0] stk_rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [7:0] last_q = 8'h5a;
   // one instruction a cycle while run_i is high, unless held or asleep
   assign retire_o = run_i && !stall_i && !sleep_i;
   // data stands one cycle only; scrambled after so late capture shows
   always @(posedge clk_i) begin
      if (stk_we_i) mem[stk_addr_i] <= stk_wdata_i;
      if (stk_re_i) last_q <= mem[stk_addr_i];
      else last_q <= ~last_q;
   end
   assign stk_rdata_o = last_q;
endmodule
`default_nettype wire

/* File: vis_top_bench.sv */
// self-checking bench for the vectored interrupt sequencer
`default_nettype none
`include "vis_consts.svh"
module vis_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_we_i = 1'b0;
   logic reg_re_i = 1'b0;
   logic [8:0] src_i = 9'h000;
   logic [2:0] q = 3'h0;
   logic sleep_i = 1'b0;
   logic run = 1'b0;
   logic [8:0] pc_i = 9'h000;
   logic [7:0] reg_rdata_o, stk_addr_o, stk_wdata_o, stk_rdata_i;
   logic retire_i, stall_o, pc_load_o, ack_o, gie_o, stk_we_o, stk_re_o;
   logic [8:0] pc_o, ret_pc;
   logic [3:0] ack_src_o;
   logic [31:0] seed = 32'h0000626b;
   int errors = 0;
   int n_compared = 0;
   int sp = 32'h9f;
   initial forever #20 clk_i = ~clk_i;
   vis_top i_dut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i,
      .reg_we_i, .reg_re_i, .reg_rdata_o, .src_i, .retire_i,
      .cli_i(q[2]), .sei_i(q[1]), .return_from_irq_instr_i(q[0]),
      .sleep_i, .pc_i, .stall_o, .pc_load_o, .pc_o, .ack_o,
      .ack_src_o, .gie_o, .stk_we_o, .stk_re_o, .stk_addr_o,
      .stk_wdata_o, .stk_rdata_i);
   vis_core_model i_core (.clk_i, .run_i(run), .sleep_i,
      .stall_i(stall_o), .retire_o(retire_i), .stk_we_i(stk_we_o),
      .stk_re_i(stk_re_o), .stk_addr_i(stk_addr_o),
      .stk_wdata_i(stk_wdata_o), .stk_rdata_o(stk_rdata_i));
   task automatic chk(input string nm, input logic [8:0] seen,
         input logic [8:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // sources ride on a write so an event can meet a clear
   task automatic wr(input logic [3:0] a, input logic [7:0] d,
         input logic [8:0] s = 9'h000);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      src_i <= s;
      @(posedge clk_i);
      reg_we_i <= 1'b0;
      src_i <= 9'h000;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e,
         input string nm);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      @(posedge clk_i);
      reg_re_i <= 1'b0;
      #1 chk(nm, {1'b0, reg_rdata_o}, {1'b0, e});
      @(posedge clk_i);
   endtask
   task automatic ins(input logic [2:0] k);
      q <= k;
      run <= 1'b1;
      @(posedge clk_i);
      q <= 3'h0;
      run <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic newpc();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      pc_i <= seed[8:0];
      ret_pc = seed[8:0];
   endtask
   // core is kept running until the load; bounded so a hang ends the run
   task automatic wload(input logic [8:0] e, input string nm);
      int n;
      run <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_i);
         #1;
         if (pc_load_o === 1'b1) break;
      end
      if (n == 40) begin
         errors++;
         summarize();
      end
      chk(nm, pc_o, e);
      @(posedge clk_i);
      run <= 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rd(`VIS_OFF_SP, 8'h9f, "sp reset");
      rd(`VIS_OFF_STATUS, 8'h00, "status reset");
      wr(4'hf, 8'h00, 9'h008);
      rd(`VIS_OFF_FLAGS, 8'h08, "flag kept");
      rd(`VIS_OFF_REQ, 8'h00, "req gated");
      wr(`VIS_OFF_FLAGS, 8'hf7);
      rd(`VIS_OFF_FLAGS, 8'h08, "zero write");
      wr(`VIS_OFF_FLAGS, 8'h08);
      rd(`VIS_OFF_FLAGS, 8'h00, "one clears");
      wr(`VIS_OFF_FLAGS, 8'h04, 9'h004);
      rd(`VIS_OFF_FLAGS, 8'h04, "set wins");
      wr(`VIS_OFF_FLAGS, 8'h04);
      $display("test flags done");
      wr(`VIS_OFF_ENABLE, 8'hbf);
      wr(4'hf, 8'h00, 9'h040);
      wr(4'hf, 8'h00, 9'h040);
      wr(`VIS_OFF_ENABLE, 8'hff);
      rd(`VIS_OFF_REQ, 8'h00, "level gone");
      $display("test level done");
      wr(`VIS_OFF_STATUS, 8'h55);
      wr(4'hf, 8'h00, 9'h021);
      ins(3'b010);
      newpc();
      wload(9'h001, "vector zero");
      chk("src", {5'h00, ack_src_o}, 9'h000);
      chk("gie off", {8'h00, gie_o}, 9'h000);
      sp = sp - 2;
      rd(`VIS_OFF_SP, sp[7:0], "sp push");
      rd(`VIS_OFF_STATUS, 8'h55, "status kept");
      rd(`VIS_OFF_FLAGS, 8'h20, "hw clear");
      ins(3'b001);
      wload(ret_pc, "ret pc");
      #1 chk("gie on", {8'h00, gie_o}, 9'h001);
      @(posedge clk_i);
      sp = sp + 2;
      rd(`VIS_OFF_SP, sp[7:0], "sp pop");
      newpc();
      wload(9'h006, "vector five");
      chk("src5", {5'h00, ack_src_o}, 9'h005);
      ins(3'b001);
      wload(ret_pc, "ret pc2");
      $display("test entry done");
      wr(`VIS_OFF_STATUS, 8'h80);
      // the sleep instruction itself retires, ending the post-return hold
      ins(3'b000);
      sleep_i <= 1'b1;
      newpc();
      wr(4'hf, 8'h00, 9'h002);
      wload(9'h002, "wake vector");
      sleep_i <= 1'b0;
      ins(3'b001);
      wload(ret_pc, "wake ret");
      $display("test sleep done");
      wr(4'hf, 8'h00, 9'h004);
      // clear the post-return hold so only the disable can block the take
      ins(3'b000);
      ins(3'b100);
      rd(`VIS_OFF_STATUS, 8'h00, "cli gie");
      rd(`VIS_OFF_FLAGS, 8'h04, "cli pending");
      $display("test disable done");
      summarize();
   end
endmodule
`default_nettype wire
